// [scfd_field_decode.sv]
// configuration storage words with apb access, decoded into signal-path settings
// assumes an apb master on clk; decoded outputs feed the signal path directly
`timescale 1ns/1ps
`default_nettype none
module scfd_field_decode (
	input  wire logic        clk,           // 50 MHz clock
	input  wire logic        reset_n,       // synchronous reset, active low
	input  wire logic        psel,          // apb select
	input  wire logic        penable,       // apb access phase
	input  wire logic        pwrite,        // apb write
	input  wire logic [11:0] paddr,         // apb byte address
	input  wire logic [31:0] pwdata,        // apb write data
	output logic      [31:0] prdata,        // apb read data
	output logic             pready,        // apb ready
	output logic             pslverr,       // apb error on unmapped address
	output logic      [1:0]  lineAddress,   // device address on shared line
	output logic      [23:0] calCornerMhz,  // calibration filter corner, mHz
	output logic      [23:0] sigCornerMhz,  // signal filter corner, mHz
	output logic      [11:0] upperLimit,    // upper clamp, 0xFFF = max level
	output logic      [11:0] lowerLimit,    // lower clamp, 0xFFF = max level
	output logic      [4:0]  timebaseSel,   // pwm rate or tick select
	output logic      [15:0] zeroOffset,    // signed zero-field offset
	output logic      [5:0]  coarseMult,    // coarse gain multiplier
	output logic      [10:0] fineGain       // fine gain, 0x400 = unity
);
	// storage words, parameter bits only
	logic [31:0] wordAddr;  // word 2
	logic [31:0] wordFilt;  // word 3
	logic [31:0] wordOffs;  // word 6
	logic [31:0] wordClamp; // word 8
	logic [31:0] wordRate;  // word 20
	logic [31:0] next_rdata; // read mux
	logic        next_err;   // unmapped decode
	logic        hit;        // address decoded
	logic [9:0]  index;      // word index
	logic        doWrite;    // write on access edge
	logic        accessPh;   // access phase

	assign index    = paddr[11:2];
	assign accessPh = psel && penable;
	assign doWrite  = accessPh && pwrite && hit;

	// address decode and read mux; reserved bits 31:26 read as zero
	always_comb
	begin
		hit = 1'b1;
		next_rdata = 32'h0000_0000;
		case (index)
			10'(scfd_pkg::IDX_ADDR):   next_rdata = wordAddr;
			10'(scfd_pkg::IDX_FILT):   next_rdata = wordFilt;
			10'(scfd_pkg::IDX_OFFS):   next_rdata = wordOffs;
			10'(scfd_pkg::IDX_CLAMP):  next_rdata = wordClamp;
			10'(scfd_pkg::IDX_RATE):   next_rdata = wordRate;
			10'(scfd_pkg::IDX_STATUS):
				next_rdata = {13'h0000, coarseMult, fineGain, lineAddress};
			default:                   hit = 1'b0;
		endcase
		next_err = !hit;
	end

	// storage writes; only the 26 parameter bits are kept
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			wordAddr  <= 32'h0000_0000;
			wordFilt  <= scfd_pkg::FILT_RESET; // fine gain unity, coarse 1x
			wordOffs  <= 32'h0000_0000;
			wordClamp <= 32'h0000_0000;        // both clamps at default
			wordRate  <= 32'h0000_0000;
		end
		else if (doWrite && index != 10'(scfd_pkg::IDX_STATUS))
		begin
			case (index)
				10'(scfd_pkg::IDX_ADDR):  wordAddr  <= {6'h00, pwdata[scfd_pkg::DATA_MSB:0]};
				10'(scfd_pkg::IDX_FILT):  wordFilt  <= {6'h00, pwdata[scfd_pkg::DATA_MSB:0]};
				10'(scfd_pkg::IDX_OFFS):  wordOffs  <= {6'h00, pwdata[scfd_pkg::DATA_MSB:0]};
				10'(scfd_pkg::IDX_CLAMP): wordClamp <= {6'h00, pwdata[scfd_pkg::DATA_MSB:0]};
				10'(scfd_pkg::IDX_RATE):  wordRate  <= {6'h00, pwdata[scfd_pkg::DATA_MSB:0]};
				default:                  wordRate  <= wordRate;
			endcase
		end
	end

	// apb answer: ready in the first access cycle, zero wait states
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && !penable;           // ready rises for the access phase
			pslverr <= psel && !penable && next_err;
			prdata  <= (psel && !penable && !pwrite) ? next_rdata : 32'h0000_0000;
		end
	end

	// line address: bit 23 high, bit 22 low
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			lineAddress <= 2'h0;
		else
			lineAddress <= {wordAddr[scfd_pkg::ADDR_HI], wordAddr[scfd_pkg::ADDR_LO]};
	end

	// filter corners; independent of any self-test timing path
	logic [2:0] calCode; // calibration filter select
	logic [2:0] sigCode; // signal filter select
	assign calCode = wordFilt[scfd_pkg::CALF_LSB +: 3];
	assign sigCode = wordFilt[scfd_pkg::SIGF_LSB +: 3];

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			calCornerMhz <= scfd_pkg::CAL_C0;
			sigCornerMhz <= scfd_pkg::SIG_C0;
		end
		else
		begin
			case (calCode)
				3'h0:    calCornerMhz <= scfd_pkg::CAL_C0;
				3'h1:    calCornerMhz <= scfd_pkg::CAL_C1;
				3'h2:    calCornerMhz <= scfd_pkg::CAL_C2;
				3'h3:    calCornerMhz <= scfd_pkg::CAL_C3;
				default: calCornerMhz <= scfd_pkg::CAL_C4; // codes 4 to 7
			endcase
			case (sigCode)
				3'h0:    sigCornerMhz <= scfd_pkg::SIG_C0;
				3'h1:    sigCornerMhz <= scfd_pkg::SIG_C1;
				3'h2:    sigCornerMhz <= scfd_pkg::SIG_C2;
				3'h3:    sigCornerMhz <= scfd_pkg::SIG_C3;
				default: sigCornerMhz <= scfd_pkg::SIG_C4; // codes 4 to 7
			endcase
		end
	end

	// clamps: upper is inverted so a stored zero gives full scale
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			upperLimit <= scfd_pkg::CLAMP_MAX;
			lowerLimit <= 12'h000;
		end
		else
		begin
			upperLimit <= scfd_pkg::CLAMP_MAX ^ wordClamp[scfd_pkg::UPC_LSB +: 12];
			lowerLimit <= wordClamp[scfd_pkg::LOC_LSB +: 12];
		end
	end

	// timebase and zero offset
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			timebaseSel <= 5'h00;
			zeroOffset  <= 16'h0000;
		end
		else
		begin
			timebaseSel <= wordRate[scfd_pkg::RATE_LSB +: 5];
			zeroOffset  <= wordOffs[scfd_pkg::OFFS_LSB +: 16];
		end
	end

	// gains: coarse code to multiplier, unused codes fall back to 1x
	logic [2:0] crsCode; // coarse gain select
	assign crsCode = wordFilt[scfd_pkg::CRS_LSB +: 3];

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			coarseMult <= 6'h01;
			fineGain   <= scfd_pkg::FINE_UNITY;
		end
		else
		begin
			if (crsCode <= scfd_pkg::CRS_MAX)
				coarseMult <= 6'(6'h01 << crsCode);
			else
				coarseMult <= 6'h01;
			fineGain <= wordFilt[scfd_pkg::FINE_LSB +: 11];
		end
	end

	// checks
	chk_line_addr: assert property (@(posedge clk) disable iff (!reset_n)
		lineAddress == {$past(wordAddr[scfd_pkg::ADDR_HI]), $past(wordAddr[scfd_pkg::ADDR_LO])})
		else $error("line address mismatch");
	chk_cal_high: assert property (@(posedge clk) disable iff (!reset_n)
		$past(calCode) >= 3'h4 |-> calCornerMhz == scfd_pkg::CAL_C4)
		else $error("calibration corner wrong");
	chk_sig_zero: assert property (@(posedge clk) disable iff (!reset_n)
		$past(sigCode) == 3'h0 |-> sigCornerMhz == scfd_pkg::SIG_C0)
		else $error("signal corner wrong");
	chk_upper_inv: assert property (@(posedge clk) disable iff (!reset_n)
		upperLimit + $past(wordClamp[scfd_pkg::UPC_LSB +: 12]) == scfd_pkg::CLAMP_MAX)
		else $error("upper clamp not inverted");
	chk_lower_pass: assert property (@(posedge clk) disable iff (!reset_n)
		lowerLimit == $past(wordClamp[scfd_pkg::LOC_LSB +: 12]))
		else $error("lower clamp wrong");
	chk_coarse_bad: assert property (@(posedge clk) disable iff (!reset_n)
		$past(crsCode) > scfd_pkg::CRS_MAX |-> coarseMult == 6'h01)
		else $error("unused coarse code not 1x");
	chk_coarse_max: assert property (@(posedge clk) disable iff (!reset_n)
		$past(crsCode) == scfd_pkg::CRS_MAX |-> coarseMult == 6'h20)
		else $error("coarse 32x wrong");
	chk_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
		wordFilt[scfd_pkg::WORD_W-1:scfd_pkg::DATA_MSB+1] == 6'h00
		&& wordClamp[scfd_pkg::WORD_W-1:scfd_pkg::DATA_MSB+1] == 6'h00
		&& wordAddr[scfd_pkg::WORD_W-1:scfd_pkg::DATA_MSB+1] == 6'h00
		&& wordOffs[scfd_pkg::WORD_W-1:scfd_pkg::DATA_MSB+1] == 6'h00
		&& wordRate[scfd_pkg::WORD_W-1:scfd_pkg::DATA_MSB+1] == 6'h00)
		else $error("reserved bits stored");

	// storage checks: an accepted write lands in its word one edge later

	// line address word takes the parameter bits of the write
	chk_addr_store: assert property (@(posedge clk) disable iff (!reset_n)
		$past(doWrite) && $past(index) == 10'(scfd_pkg::IDX_ADDR) |-> wordAddr[scfd_pkg::DATA_MSB:0] == $past(pwdata[scfd_pkg::DATA_MSB:0]))
		else $error("address word not stored");

	// filter and gain word takes the parameter bits of the write
	chk_filt_store: assert property (@(posedge clk) disable iff (!reset_n)
		$past(doWrite) && $past(index) == 10'(scfd_pkg::IDX_FILT) |-> wordFilt[scfd_pkg::DATA_MSB:0] == $past(pwdata[scfd_pkg::DATA_MSB:0]))
		else $error("filter word not stored");

	// offset word takes the parameter bits of the write
	chk_offs_store: assert property (@(posedge clk) disable iff (!reset_n)
		$past(doWrite) && $past(index) == 10'(scfd_pkg::IDX_OFFS) |-> wordOffs[scfd_pkg::DATA_MSB:0] == $past(pwdata[scfd_pkg::DATA_MSB:0]))
		else $error("offset word not stored");

	// clamp word takes the parameter bits of the write
	chk_clamp_store: assert property (@(posedge clk) disable iff (!reset_n)
		$past(doWrite) && $past(index) == 10'(scfd_pkg::IDX_CLAMP) |-> wordClamp[scfd_pkg::DATA_MSB:0] == $past(pwdata[scfd_pkg::DATA_MSB:0]))
		else $error("clamp word not stored");

	// timebase word takes the parameter bits of the write
	chk_rate_store: assert property (@(posedge clk) disable iff (!reset_n)
		$past(doWrite) && $past(index) == 10'(scfd_pkg::IDX_RATE) |-> wordRate[scfd_pkg::DATA_MSB:0] == $past(pwdata[scfd_pkg::DATA_MSB:0]))
		else $error("timebase word not stored");

	// pass-through fields follow their words one edge later

	// fine gain is the low eleven bits of the filter word
	chk_fine_pass: assert property (@(posedge clk) disable iff (!reset_n)
		fineGain == $past(wordFilt[scfd_pkg::FINE_LSB +: 11]))
		else $error("fine gain wrong");

	// timebase select is the five-bit field of its word
	chk_time_pass: assert property (@(posedge clk) disable iff (!reset_n)
		timebaseSel == $past(wordRate[scfd_pkg::RATE_LSB +: 5]))
		else $error("timebase select wrong");

	// zero offset is the low sixteen bits of its word
	chk_offs_pass: assert property (@(posedge clk) disable iff (!reset_n)
		zeroOffset == $past(wordOffs[scfd_pkg::OFFS_LSB +: 16]))
		else $error("zero offset wrong");

	// calibration corner, code zero
	chk_cal_zero: assert property (@(posedge clk) disable iff (!reset_n)
		$past(calCode) == 3'h0 |-> calCornerMhz == scfd_pkg::CAL_C0)
		else $error("calibration corner code 0 wrong");

	// calibration corner, code one
	chk_cal_one: assert property (@(posedge clk) disable iff (!reset_n)
		$past(calCode) == 3'h1 |-> calCornerMhz == scfd_pkg::CAL_C1)
		else $error("calibration corner code 1 wrong");

	// calibration corner, code two
	chk_cal_two: assert property (@(posedge clk) disable iff (!reset_n)
		$past(calCode) == 3'h2 |-> calCornerMhz == scfd_pkg::CAL_C2)
		else $error("calibration corner code 2 wrong");

	// calibration corner, code three
	chk_cal_three: assert property (@(posedge clk) disable iff (!reset_n)
		$past(calCode) == 3'h3 |-> calCornerMhz == scfd_pkg::CAL_C3)
		else $error("calibration corner code 3 wrong");

	// calibration corner moves only when its own code moved
	chk_cal_own: assert property (@(posedge clk) disable iff (!reset_n)
		$changed(calCornerMhz) |-> $past(calCode, 1) != $past(calCode, 2))
		else $error("calibration corner moved without its code");

	// signal corner, code one
	chk_sig_one: assert property (@(posedge clk) disable iff (!reset_n)
		$past(sigCode) == 3'h1 |-> sigCornerMhz == scfd_pkg::SIG_C1)
		else $error("signal corner code 1 wrong");

	// signal corner, code two
	chk_sig_two: assert property (@(posedge clk) disable iff (!reset_n)
		$past(sigCode) == 3'h2 |-> sigCornerMhz == scfd_pkg::SIG_C2)
		else $error("signal corner code 2 wrong");

	// signal corner, code three
	chk_sig_three: assert property (@(posedge clk) disable iff (!reset_n)
		$past(sigCode) == 3'h3 |-> sigCornerMhz == scfd_pkg::SIG_C3)
		else $error("signal corner code 3 wrong");

	// signal corner, codes four to seven share the top corner
	chk_sig_high: assert property (@(posedge clk) disable iff (!reset_n)
		$past(sigCode) >= 3'h4 |-> sigCornerMhz == scfd_pkg::SIG_C4)
		else $error("signal corner high codes wrong");

	// coarse gain, code zero is the 1x default
	chk_coarse_one: assert property (@(posedge clk) disable iff (!reset_n)
		$past(crsCode) == 3'h0 |-> coarseMult == 6'h01)
		else $error("coarse 1x wrong");

	// coarse gain, code one
	chk_coarse_two: assert property (@(posedge clk) disable iff (!reset_n)
		$past(crsCode) == 3'h1 |-> coarseMult == 6'h02)
		else $error("coarse 2x wrong");

	// coarse gain, code two
	chk_coarse_four: assert property (@(posedge clk) disable iff (!reset_n)
		$past(crsCode) == 3'h2 |-> coarseMult == 6'h04)
		else $error("coarse 4x wrong");

	// coarse gain, code three
	chk_coarse_eight: assert property (@(posedge clk) disable iff (!reset_n)
		$past(crsCode) == 3'h3 |-> coarseMult == 6'h08)
		else $error("coarse 8x wrong");

	// coarse gain, code four
	chk_coarse_sixteen: assert property (@(posedge clk) disable iff (!reset_n)
		$past(crsCode) == 3'h4 |-> coarseMult == 6'h10)
		else $error("coarse 16x wrong");

	// bus answer checks

	// ready stands only in the cycle after a setup cycle
	chk_ready_pulse: assert property (@(posedge clk) disable iff (!reset_n)
		pready |-> $past(psel) && !$past(penable))
		else $error("ready outside access cycle");

	// an error is only ever shown together with ready
	chk_err_ready: assert property (@(posedge clk) disable iff (!reset_n)
		pslverr |-> pready)
		else $error("error without ready");

	// read data is zero whenever no read answer stands
	chk_read_zero: assert property (@(posedge clk) disable iff (!reset_n)
		!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside answer");
endmodule
`default_nettype wire

// [scfd_pkg.sv]
// constants for the configuration field decode block: word offsets, field positions, codes
// assumes 32-bit apb with word-aligned byte addresses; storage words are held as flops in the top module
package scfd_pkg;
	// word indices as printed; byte address is four times these
	localparam logic [7:0] IDX_ADDR   = 8'h02; // line address word
	localparam logic [7:0] IDX_FILT   = 8'h03; // filter and gain word
	localparam logic [7:0] IDX_OFFS   = 8'h06; // zero offset word
	localparam logic [7:0] IDX_CLAMP  = 8'h08; // clamp word
	localparam logic [7:0] IDX_RATE   = 8'h14; // output timebase word
	localparam logic [7:0] IDX_STATUS = 8'h40; // decoded status word
	localparam int WORD_W   = 32; // storage word width
	localparam int DATA_MSB = 25; // highest parameter bit
	// field positions
	localparam int ADDR_LO  = 22; // line address low bit
	localparam int ADDR_HI  = 23; // line address high bit
	localparam int CALF_LSB = 19; // calibration filter
	localparam int SIGF_LSB = 16; // signal filter
	localparam int CRS_LSB  = 12; // coarse gain
	localparam int FINE_LSB = 0;  // fine gain
	localparam int UPC_LSB  = 0;  // upper clamp
	localparam int LOC_LSB  = 12; // lower clamp
	localparam int RATE_LSB = 3;  // timebase select
	localparam int OFFS_LSB = 0;  // zero offset
	// reset values and coarse code limit
	localparam logic [10:0] FINE_UNITY = 11'h400;          // unity fine gain
	localparam logic [31:0] FILT_RESET = 32'h0000_0400;    // word 3 default
	localparam logic [11:0] CLAMP_MAX  = 12'hFFF;          // full-scale clamp
	localparam logic [2:0]  CRS_MAX    = 3'h5;             // highest valid coarse code
	// corner frequencies, in millihertz
	localparam logic [23:0] CAL_C0 = 24'h000050; // 0.08 Hz
	localparam logic [23:0] CAL_C1 = 24'h00012C; // 0.3 Hz
	localparam logic [23:0] CAL_C2 = 24'h0004E2; // 1.25 Hz
	localparam logic [23:0] CAL_C3 = 24'h000FA0; // 4 Hz
	localparam logic [23:0] CAL_C4 = 24'h003E80; // 16 Hz
	localparam logic [23:0] SIG_C0 = 24'h009C40; // 40 Hz
	localparam logic [23:0] SIG_C1 = 24'h027100; // 160 Hz
	localparam logic [23:0] SIG_C2 = 24'h0A6040; // 680 Hz
	localparam logic [23:0] SIG_C3 = 24'h2DC6C0; // 3000 Hz
	localparam logic [23:0] SIG_C4 = 24'h70EAC0; // 7400.128 Hz
endpackage

// [testbench.sv]
// self-checking bench for the configuration field decode block
// assumes the apb slave answers in a bounded time and decodes one clock after a store
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk = 1'b0;       // 50 MHz clock
	logic        reset_n = 1'b0;   // active low reset
	logic        psel = 1'b0;      // apb select
	logic        penable = 1'b0;   // apb access phase
	logic        pwrite = 1'b0;    // apb direction
	logic [11:0] paddr = 12'h000;  // apb byte address
	logic [31:0] pwdata = 32'h0;   // apb write data
	logic [31:0] prdata;           // apb read data
	logic        pready;           // apb ready
	logic        pslverr;          // apb error
	logic [1:0]  lineAddress;      // decoded line address
	logic [23:0] calCornerMhz;     // calibration corner
	logic [23:0] sigCornerMhz;     // signal corner
	logic [11:0] upperLimit;       // upper clamp level
	logic [11:0] lowerLimit;       // lower clamp level
	logic [4:0]  timebaseSel;      // timebase select
	logic [15:0] zeroOffset;       // zero-field offset
	logic [5:0]  coarseMult;       // coarse multiplier
	logic [10:0] fineGain;         // fine gain
	logic [31:0] rdData;           // data taken at the ready edge
	logic        rdErr;            // error taken at the ready edge
	int          miscompares = 0;  // mismatches seen
	int          checksDone = 0;   // comparisons made
	// expected corners and multipliers, indexed by code
	logic [23:0] expCal [8] = '{24'h50, 24'h12C, 24'h4E2, 24'hFA0, 24'h3E80, 24'h3E80, 24'h3E80, 24'h3E80};
	logic [23:0] expSig [8] = '{24'h9C40, 24'h27100, 24'hA6040, 24'h2DC6C0, 24'h70EAC0, 24'h70EAC0,
		24'h70EAC0, 24'h70EAC0};
	logic [5:0]  expCrs [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h01, 6'h01};
	scfd_field_decode scfd_field_decode_inst (.clk(clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lineAddress(lineAddress), .calCornerMhz(calCornerMhz),
		.sigCornerMhz(sigCornerMhz), .upperLimit(upperLimit), .lowerLimit(lowerLimit),
		.timebaseSel(timebaseSel), .zeroOffset(zeroOffset), .coarseMult(coarseMult), .fineGain(fineGain));
	// clock toggles every half period
	always #10 clk = ~clk;
	// compare and report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer, entered just after a rising edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// look mid-cycle: registered answers stand settled up to the next rising edge
		@(negedge clk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 20)
			miscompares++;
		rdData = prdata;
		rdErr = pslverr;
		@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// write, then let the decoded outputs follow
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
		repeat (2) @(posedge clk);
	endtask
	// decoded values after any reset
	task automatic chkReset();
		chk(32'(lineAddress), 32'h0);
		chk(32'(calCornerMhz), 32'h50);
		chk(32'(sigCornerMhz), 32'h9C40);
		chk(32'(upperLimit), 32'hFFF);
		chk(32'(lowerLimit), 32'h0);
		chk(32'(coarseMult), 32'h1);
		chk(32'(fineGain), 32'h400);
		chk(32'(timebaseSel), 32'h0);
		chk(32'(zeroOffset), 32'h0);
		chk(prdata, 32'h0);
		chk(32'(pslverr), 32'h0);
	endtask
	// report counts and verdict, then end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// watchdog against a hung handshake
	initial
	begin
		#200000;
		miscompares++;
		stop_test();
	end
	// main sequence
	initial
	begin
		logic [31:0] w;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		chkReset();
		// row loop: one code of each field per row, reserved bits 31:26 set
		for (int c = 0; c < 8; c++)
		begin
			w = 32'hFC00_0000 | (c << 19) | ((7 - c) << 16) | (c << 12) | (32'h400 ^ c);
			wr(12'h00C, w);
			chk(32'(calCornerMhz), 32'(expCal[c]));
			chk(32'(sigCornerMhz), 32'(expSig[7 - c]));
			chk(32'(coarseMult), 32'(expCrs[c]));
			chk(32'(fineGain), 32'h400 ^ c);
			xfer(1'b0, 12'h00C, 32'h0);
			chk(rdData, w & 32'h03FF_FFFF);
		end
		// line address, every combination
		for (int a = 0; a < 4; a++)
		begin
			wr(12'h008, a << 22);
			chk(32'(lineAddress), a);
		end
		wr(12'h020, 32'h00AB_C123);
		chk(32'(upperLimit), 32'hEDC);
		chk(32'(lowerLimit), 32'hABC);
		wr(12'h018, 32'hFFFF_8001);
		chk(32'(zeroOffset), 32'h8001);
		wr(12'h050, 32'hFFFF_FFAF);
		chk(32'(timebaseSel), 32'h15);
		// status is read-only, a write there is dropped
		wr(12'h100, 32'hFFFF_FFFF);
		xfer(1'b0, 12'h100, 32'h0);
		chk(rdData, {13'h0, 6'h01, 11'h407, 2'h3});
		// unmapped address is refused
		xfer(1'b1, 12'h004, 32'h1234_5678);
		chk(32'(rdErr), 32'h1);
		xfer(1'b0, 12'h004, 32'h0);
		chk(rdData, 32'h0);
		// reset in mid-run restores defaults
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		chkReset();
		stop_test();
	end
endmodule
`default_nettype wire
